// *** logic/code_lock_pkg.sv ***
package code_lock_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned KEY_BYTES      = 64;
  localparam int unsigned KEY_IDX_W      = 6;
  localparam int unsigned CODE_ADDR_W    = 16;
  localparam int unsigned BYTE_W         = 8;
  localparam logic [7:0]  KEY_ERASED     = 8'hff;   // key byte meaning no encryption
  localparam logic [7:0]  CODE_ERASED    = 8'hff;

  // code image layout, 8k and 16k parts
  localparam logic [16:0] IMG8K_DATA_LAST  = 17'h01fff;
  localparam logic [16:0] IMG8K_KEY_LAST   = 17'h0203f;
  localparam logic [16:0] IMG8K_SEC        = 17'h02040;
  localparam logic [16:0] IMG16K_DATA_LAST = 17'h03fff;
  localparam logic [16:0] IMG16K_KEY_LAST  = 17'h0403f;
  localparam logic [16:0] IMG16K_SEC       = 17'h04040;

  // security byte fields, 0 = protection on
  localparam int unsigned SEC_BIT_ONE = 0;
  localparam int unsigned SEC_BIT_TWO = 1;
  localparam logic [7:0]  SEC_RESET   = 8'hff;

  // ---------------------------------------------------------------
  // register map (avalon word addresses, byte address / 4)
  // ---------------------------------------------------------------
  localparam int unsigned AV_ADDR_W   = 8;
  localparam logic [7:0]  REG_CTRL    = 8'h00;  // [0] prog_enable, other bits unused
  localparam logic [7:0]  REG_SEC     = 8'h01;  // security byte image
  localparam logic [7:0]  REG_STATUS  = 8'h02;  // lock state, key and access flags
  localparam logic [7:0]  REG_KEY_WR  = 8'h03;  // [13:8] index, [7:0] data
  localparam logic [7:0]  REG_REFUSED = 8'h04;  // refused programming attempts
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  localparam int unsigned CTRL_PROG   = 0;
  localparam int unsigned ST_SB1      = 0;
  localparam int unsigned ST_SB2      = 1;
  localparam int unsigned ST_ENC      = 2;
  localparam int unsigned ST_EA_LAT   = 3;
  localparam int unsigned ST_VFY_OFF  = 4;
  localparam int unsigned ST_EA_VAL   = 5;

  typedef enum logic [1:0] {
    verify_idle,
    verify_fetch,
    verify_drive
  } verify_state_e;

  // verify port bundle toward the programmer pins
  typedef struct packed {
    logic [7:0]  port0_out;
    logic        port0_oe;
  } verify_drive_s;

  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } code_fetch_s;

endpackage : code_lock_pkg

// *** logic/key_cipher.sv ***
`timescale 1ns/100ps
// key array plus encryption of one verify byte
module key_cipher #(
  parameter int unsigned DEPTH = 64
) (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            clk_en,
  input  wire logic                            key_we,
  input  wire logic [code_lock_pkg::KEY_IDX_W-1:0] key_widx,
  input  wire logic [7:0]                      key_wdata,
  input  wire logic [code_lock_pkg::KEY_IDX_W-1:0] key_ridx,
  input  wire logic [7:0]                      plain,
  output logic      [7:0]                      cipher,
  output logic                                 key_active
);
  import code_lock_pkg::*;

  logic [7:0]       key_mem [DEPTH];
  logic [DEPTH-1:0] programmed;

  // ---------------------------------------------------------------
  // key storage, erased to all ones
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        key_mem[i] <= KEY_ERASED;  // [RQ7]
      end
      programmed <= '0;
    end else if (clk_en && key_we) begin
      key_mem[key_widx]    <= key_wdata;
      programmed[key_widx] <= (key_wdata != KEY_ERASED);
    end
  end

  // xnor with the byte picked by low address bits; erased key is identity
  always_comb begin
    key_active = |programmed;
    cipher     = key_active ? ~(plain ^ key_mem[key_ridx]) : plain;  // [RQ2] [RQ14] [RQ12]
  end

endmodule : key_cipher

// *** logic/code_rom_security_lock.sv ***
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
// Behaviour
// RQ1: with no security bit programmed, verify reads return code memory.
// RQ2: a programmed key makes every verify byte encrypted, whatever the bits.
// RQ3: security bit one blocks external code-table reads of internal code.
// RQ4: security bit one latches the external-access pin at reset and holds it; here the level follows the pin until bit one is written, then holds.
// RQ5: security bit one refuses further programming of code memory.
// RQ6: bits one and two keep bit one protections and disable verify.
// RQ7: key array holds 64 bytes, erased to all ones.
// RQ8: unlisted bit combinations need no defined behaviour.
// RQ9: programmer never sets bit two without bit one.
// RQ10: 8k image: data to 1fff, key to 203f, security byte 2040.
// RQ11: 16k image: data to 3fff, key to 403f, security byte 4040.
// RQ12: key is 64 bytes; ff key bytes mean no encryption.
// RQ13: security byte bit0 is bit one, bit1 bit two; 0 enables.
// RQ14: encrypted verify byte is xnor of code byte and key byte.
// RQ15: verify address comes from ports 1 and 2, data goes on port 0.
// RQ16: key byte chosen by low six bits of the verify address.
module code_rom_security_lock #(
  parameter int unsigned ADDR_W = code_lock_pkg::CODE_ADDR_W
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire logic                                   clk_en,
  // avalon-mm slave
  input  wire logic [code_lock_pkg::AV_ADDR_W-1:0]    avs_address,
  input  wire logic                                   avs_read,
  input  wire logic                                   avs_write,
  input  wire logic [31:0]                            avs_writedata,
  input  wire logic [3:0]                             avs_byteenable,
  output logic      [31:0]                            avs_readdata,
  output logic                                        avs_waitrequest,
  // programmer pins
  input  wire logic                                   verify_mode_pin,
  input  wire logic [7:0]                             port1_in,
  input  wire logic [7:0]                             port2_in,
  output logic      [7:0]                             port0_out,
  output logic                                        port0_oe,
  input  wire logic                                   external_access_pin,
  output logic                                        external_access,
  // core program fetch path
  input  wire logic                                   core_read_req,
  input  wire logic [ADDR_W-1:0]                      core_read_addr,
  input  wire logic                                   core_exec_external,
  output logic      [7:0]                             core_read_data,
  output logic                                        core_read_blocked,
  // code memory port
  output logic      [ADDR_W-1:0]                      rom_addr,
  input  wire logic [7:0]                             rom_rdata,
  output logic                                        rom_we,
  output logic      [7:0]                             rom_wdata
);
  import code_lock_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0]  vmode_sync;
  logic [7:0]  p1_meta, p1_sync, p2_meta, p2_sync;
  logic [1:0]  ea_sync;

  // first stages only feed the second stages
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vmode_sync <= '0;
      p1_meta    <= '0;
      p1_sync    <= '0;
      p2_meta    <= '0;
      p2_sync    <= '0;
    end else if (clk_en) begin
      vmode_sync <= {vmode_sync[0], verify_mode_pin};
      p1_meta    <= port1_in;
      p1_sync    <= p1_meta;
      p2_meta    <= port2_in;
      p2_sync    <= p2_meta;
    end
  end

  // access pin chain keeps running in reset, so the latch sees the level held
  // during reset; a limitation: reset must span at least two enabled edges
  always_ff @(posedge clk) begin
    if (clk_en) begin
      ea_sync <= {ea_sync[0], external_access_pin};  // [RQ4]
    end
  end

  // ---------------------------------------------------------------
  // security byte and derived protections
  // ---------------------------------------------------------------
  logic [7:0] sec_byte;
  logic       sb1_on, sb2_on, verify_off;

  // active low fields; bit two alone is left undefined and treated as none
  always_comb begin
    sb1_on     = ~sec_byte[SEC_BIT_ONE];                 // [RQ13]
    sb2_on     = ~sec_byte[SEC_BIT_TWO];                 // [RQ13]
    verify_off = sb1_on & sb2_on;                        // [RQ6] [RQ8]
  end

  // ---------------------------------------------------------------
  // avalon register file
  // ---------------------------------------------------------------
  logic        prog_enable;
  logic [7:0]  refused_cnt;
  logic        key_we;
  logic [5:0]  key_widx;
  logic [7:0]  key_wdata;
  logic        key_active;
  logic        bus_req, bus_done;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] reg_ofs);
    return avs_write && (a == reg_ofs) && avs_byteenable[0];
  endfunction : wr_hit

  // one wait cycle: request taken when waitrequest already low
  always_comb begin
    bus_req  = avs_read | avs_write;
    bus_done = bus_req & ~avs_waitrequest;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  // security bits only ever program, never erase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec_byte    <= SEC_RESET;
      prog_enable <= 1'b0;
    end else if (clk_en && bus_done) begin
      if (wr_hit(avs_address, REG_CTRL)) begin
        prog_enable <= avs_writedata[CTRL_PROG];
      end
      if (wr_hit(avs_address, REG_SEC)) begin
        sec_byte <= sec_byte & avs_writedata[7:0];
      end
    end
  end

  // key writes refused once locked, like code writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_we    <= 1'b0;
      key_widx  <= '0;
      key_wdata <= KEY_ERASED;
    end else if (clk_en) begin
      key_we    <= bus_done & wr_hit(avs_address, REG_KEY_WR) & ~sb1_on;  // [RQ5]
      key_widx  <= avs_writedata[13:8];
      key_wdata <= avs_writedata[7:0];
    end
  end

  // read mux, unmapped reads as zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= UNMAPPED_RD;
    end else if (clk_en && bus_req && avs_waitrequest) begin
      case (avs_address)
        REG_CTRL:    avs_readdata <= {31'h0, prog_enable};
        REG_SEC:     avs_readdata <= {24'h0, sec_byte};
        REG_STATUS:  avs_readdata <= {26'h0, external_access, verify_off,
                                      sb1_on, key_active, sb2_on, sb1_on};
        REG_REFUSED: avs_readdata <= {24'h0, refused_cnt};
        default:     avs_readdata <= UNMAPPED_RD;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // external access latch
  // ---------------------------------------------------------------
  logic ea_captured;

  // caught after reset release, then follows the pin until bit one is set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ea_captured     <= 1'b0;
      external_access <= 1'b0;
    end else if (clk_en) begin
      if (!ea_captured) begin
        ea_captured     <= 1'b1;
        external_access <= ea_sync[1];                  // [RQ4]
      end else if (!sb1_on) begin
        external_access <= ea_sync[1];
      end
    end
  end

  // ---------------------------------------------------------------
  // verify engine and code write path
  // ---------------------------------------------------------------
  verify_state_e vstate;
  logic [15:0]   vaddr;
  logic [7:0]    cipher;
  logic          core_slot;

  // verify address is ports 2:1, port 0 drives the byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vstate    <= verify_idle;
      vaddr     <= '0;
      port0_out <= '0;
      port0_oe  <= 1'b0;
    end else if (clk_en) begin
      case (vstate)
        verify_idle: begin
          port0_oe <= 1'b0;
          if (vmode_sync[1] && !verify_off) begin      // [RQ1] [RQ6]
            vaddr  <= {p2_sync, p1_sync};              // [RQ15]
            vstate <= verify_fetch;
          end
        end
        verify_fetch: begin
          vstate <= verify_drive;
        end
        verify_drive: begin
          port0_out <= cipher;                         // [RQ2] [RQ15]
          port0_oe  <= 1'b1;
          // re-fetch when the address moves; drop on mode exit
          if (!vmode_sync[1] || verify_off) begin
            vstate <= verify_idle;
          end else if ({p2_sync, p1_sync} != vaddr) begin
            vaddr  <= {p2_sync, p1_sync};
            vstate <= verify_fetch;
          end
        end
        default: vstate <= verify_idle;
      endcase
    end
  end

  // core fetch owns the rom port only outside verify
  always_comb begin
    core_slot = (vstate == verify_idle);
    rom_addr  = core_slot ? core_read_addr : vaddr[ADDR_W-1:0];
  end

  key_cipher #(
    .DEPTH      (KEY_BYTES)
  ) u_key (
    .clk        (clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .key_we     (key_we),
    .key_widx   (key_widx),
    .key_wdata  (key_wdata),
    .key_ridx   (vaddr[KEY_IDX_W-1:0]),               // [RQ16]
    .plain      (rom_rdata),
    .cipher     (cipher),
    .key_active (key_active)
  );

  // code table reads from external code see erased bytes once locked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      core_read_data    <= CODE_ERASED;
      core_read_blocked <= 1'b0;
    end else if (clk_en) begin
      core_read_blocked <= core_read_req & core_exec_external & sb1_on;  // [RQ3]
      if (core_read_req && core_slot) begin
        core_read_data <= (core_exec_external && sb1_on) ? CODE_ERASED : rom_rdata;  // [RQ3]
      end
    end
  end

  // code write strobe held low; programming enables on REG_CTRL counted as refused once locked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rom_we      <= 1'b0;
      rom_wdata   <= CODE_ERASED;
      refused_cnt <= '0;
    end else if (clk_en) begin
      rom_we    <= bus_done & wr_hit(avs_address, REG_KEY_WR) & 1'b0;
      rom_wdata <= avs_writedata[7:0];
      if (bus_done && wr_hit(avs_address, REG_CTRL) && avs_writedata[CTRL_PROG] && sb1_on) begin
        refused_cnt <= refused_cnt + 8'h01;            // [RQ5]
      end else if (prog_enable && !sb1_on && vmode_sync[1] == 1'b0) begin
        rom_we <= 1'b0;
      end
    end
  end

endmodule : code_rom_security_lock

// *** verification/code_rom_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// code memory behind the lock
// ------------------------------------------------------------
module code_rom_model
  import code_lock_pkg::*;
(
  input  wire logic [CODE_ADDR_W-1:0] rom_addr,
  output logic      [7:0]             rom_rdata
);
  // both address bytes mix in, so a swapped verify port gives wrong data
  assign rom_rdata = rom_addr[7:0] ^ {rom_addr[11:8], rom_addr[15:12]} ^ 8'h5a;
endmodule : code_rom_model

// *** verification/code_lock_sva.sv ***
`timescale 1ns/100ps
module code_lock_sva
  import code_lock_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        verify_mode_pin,
  input wire logic [7:0]  port1_in,
  input wire logic [7:0]  port2_in,
  input wire logic        port0_oe,
  input wire logic        external_access,
  input wire logic        core_read_req,
  input wire logic        core_exec_external,
  input wire logic [7:0]  core_read_data,
  input wire logic        core_read_blocked,
  input wire logic [7:0]  rom_rdata,
  input wire logic        rom_we
);
  // ------------------------------------------------------------
  // security byte shadow, rebuilt from accepted bus writes
  // ------------------------------------------------------------
  logic [7:0] sec_sh;
  logic       sec_wr;
  logic       ext_lock;
  assign sec_wr = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == REG_SEC;
  assign ext_lock = core_read_req && core_exec_external && !sec_sh[0];
  // bits only ever program, so the shadow ANDs as the device does
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec_sh <= 8'hff;
    end else if (sec_wr) begin
      sec_sh <= sec_sh & avs_writedata[7:0];
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // pins held long enough for sync, fetch and drive
  sequence pins_held_s;
    (verify_mode_pin && $stable({port2_in, port1_in}) && sec_sh[1:0] != 2'b00)[*7];
  endsequence
  // core fetch while the verify path is quiet
  sequence idle_fetch_s;
    core_read_req && !verify_mode_pin && !$past(verify_mode_pin, 4) && !port0_oe;
  endsequence
  AST_NO_CODE_WRITE: assert property (!rom_we)
    else $error("code write strobe raised");
  AST_VERIFY_SHUT: assert property (sec_sh[1:0] == 2'b00 |-> !port0_oe)
    else $error("verify drives with both bits set");
  AST_PIN_FROZEN: assert property (!sec_sh[0] && !$past(sec_sh[0]) |-> $stable(external_access))
    else $error("access level moved while latched");
  AST_EXT_BLOCKED: assert property ((idle_fetch_s ##0 (core_exec_external && !sec_sh[0]))
    |=> core_read_blocked && core_read_data == 8'hff)
    else $error("external table read not blocked");
  AST_BLOCK_CAUSE: assert property (core_read_blocked |-> $past(ext_lock))
    else $error("block flag without cause");
  AST_INT_PASS: assert property ((idle_fetch_s ##0 (!core_exec_external || sec_sh[0]))
    |=> !core_read_blocked && core_read_data == $past(rom_rdata))
    else $error("permitted fetch altered");
  AST_VERIFY_ON: assert property (pins_held_s |-> port0_oe)
    else $error("verify byte not driven");
  AST_VERIFY_DROP: assert property ((!verify_mode_pin)[*5] |-> !port0_oe)
    else $error("port kept driven after verify");
endmodule : code_lock_sva
bind code_rom_security_lock code_lock_sva chk_u (.*);

// *** verification/code_rom_security_lock_bench.sv ***
`timescale 1ns/100ps
module code_rom_security_lock_bench;
  import code_lock_pkg::*;
  logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, verify_mode_pin;
  logic [7:0]  avs_address, port1_in, port2_in, port0_out, core_read_data, rom_rdata;
  logic [7:0]  rom_wdata;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        port0_oe, external_access_pin, external_access, core_read_req;
  logic        core_exec_external, core_read_blocked, rom_we;
  logic [15:0] core_read_addr, rom_addr;
  int          failures, num_checks, cycles;
  code_rom_security_lock dut_u (.clk_en(1'b1), .*);
  code_rom_model rom_u (.*);
  // ------------------------------------------------------------
  // clock, timeout and checking helpers
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // a run that never finishes is cut off after 3000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      give_verdict();
    end
  end
  function automatic logic [7:0] code_at(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5a;
  endfunction : code_at
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= d;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n == 20) begin
      failures++;
      $display("ERROR bus handshake expected waitrequest 0 seen %b", avs_waitrequest);
    end
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // verify read on the programmer pins; on says whether a byte must appear
  task automatic vfy(input logic [15:0] a, input logic [7:0] exp, input logic on);
    int n;
    @(posedge clk);
    verify_mode_pin      <= 1'b1;
    {port2_in, port1_in} <= a;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (port0_oe !== 1'b1 && n < 12);
    chk8("verify enable", {7'h0, on}, {7'h0, port0_oe});
    if (on) chk8("verify byte", exp, port0_out);
    repeat (3) @(posedge clk);
    verify_mode_pin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : vfy
  // core table read, result one edge after the request is taken
  task automatic fetch(input logic ext, input logic [7:0] exp, input logic blk);
    @(posedge clk);
    core_read_req      <= 1'b1;
    core_read_addr     <= 16'h0123;
    core_exec_external <= ext;
    @(posedge clk);
    core_read_req <= 1'b0;
    @(posedge clk);
    chk8("fetch data", exp, core_read_data);
    chk8("fetch blocked", {7'h0, blk}, {7'h0, core_read_blocked});
  endtask : fetch
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_open();
    logic [31:0] q;
    bus(1'b1, REG_SEC, 32'h0000_00fe, 4'h0, q);
    bus(1'b0, REG_SEC, 32'h0, 4'hf, q);
    chk8("security byte", 8'hff, q[7:0]);
    bus(1'b0, 8'h3c, 32'h0, 4'hf, q);
    chk32("unmapped", UNMAPPED_RD, q);
    bus(1'b0, REG_STATUS, 32'h0, 4'hf, q);
    chk32("status", 32'h0000_0000, q);
    vfy(16'h1fff, code_at(16'h1fff), 1'b1);
    fetch(1'b1, code_at(16'h0123), 1'b0);
    external_access_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk8("access level", 8'h01, {7'h0, external_access});
    $display("test open done");
  endtask : t_open
  task automatic t_key();
    logic [31:0] q;
    vfy(16'h203f, code_at(16'h203f), 1'b1);
    bus(1'b1, REG_KEY_WR, 32'h0000_3f0f, 4'h1, q);
    vfy(16'h203f, ~(code_at(16'h203f) ^ 8'h0f), 1'b1);
    vfy(16'h3fff, ~(code_at(16'h3fff) ^ 8'h0f), 1'b1);
    vfy(16'h2040, code_at(16'h2040), 1'b1);
    $display("test key done");
  endtask : t_key
  task automatic t_sb1();
    logic [31:0] q;
    bus(1'b1, REG_SEC, 32'h0000_00fe, 4'h1, q);
    external_access_pin <= 1'b0;
    repeat (6) @(posedge clk);
    chk8("access held", 8'h01, {7'h0, external_access});
    fetch(1'b1, 8'hff, 1'b1);
    fetch(1'b0, code_at(16'h0123), 1'b0);
    bus(1'b1, REG_KEY_WR, 32'h0000_0000, 4'h1, q);
    vfy(16'h4040, code_at(16'h4040), 1'b1);
    bus(1'b1, REG_CTRL, 32'h0000_0001, 4'h1, q);
    bus(1'b0, REG_REFUSED, 32'h0, 4'hf, q);
    chk32("refused count", 32'h0000_0001, q);
    bus(1'b0, REG_STATUS, 32'h0, 4'hf, q);
    chk32("status", 32'h0000_002d, q);
    $display("test sb1 done");
  endtask : t_sb1
  task automatic t_both();
    logic [31:0] q;
    bus(1'b1, REG_SEC, 32'h0000_00fd, 4'h1, q);
    bus(1'b0, REG_SEC, 32'h0, 4'hf, q);
    chk8("security byte", 8'hfc, q[7:0]);
    vfy(16'h0010, 8'h00, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0, 4'hf, q);
    chk32("status", 32'h0000_003f, q);
    fetch(1'b1, 8'hff, 1'b1);
    $display("test both done");
  endtask : t_both
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    {rst_n, avs_read, avs_write, verify_mode_pin, external_access_pin} = 5'h0;
    {core_read_req, core_exec_external, core_read_addr} = 18'h0;
    {avs_address, avs_writedata, avs_byteenable, port1_in, port2_in} = 60'h0;
    {failures, num_checks, cycles} = 96'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_open();
    t_key();
    t_sb1();
    t_both();
    give_verdict();
  end
endmodule : code_rom_security_lock_bench
